//--- stack_exec_pkg.sv
// Shared constants and types for the extended stack instruction executor
package stack_exec_pkg;
    localparam int          PC_W        = 21;
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 8;
    localparam int          OFF_W       = 7;
    localparam int          MEM_DEPTH   = 4096;
    // Opcodes
    localparam logic [15:0] OP_CALL     = 16'h0014;
    localparam logic [7:0]  OP_MOVE_HI  = 8'heb;
    localparam logic [7:0]  OP_PUSH_HI  = 8'hfa;
    localparam logic [3:0]  SECOND_NIB  = 4'hf;
    // Field positions
    localparam int          MOVE_SS_BIT = 7;
    // Values after reset and arithmetic steps
    localparam logic [20:0] RESET_PC    = 21'h000000;
    localparam logic [20:0] PC_STEP     = 21'h000002;
    localparam logic [11:0] RESET_SSP   = 12'h000;
    localparam logic [11:0] SSP_STEP    = 12'h001;
    localparam logic [7:0]  NULL_DATA   = 8'h00;
    // Indirect access windows: three groups of IND_SPAN bytes
    localparam logic [11:0] IND_BASE0   = 12'hfd0;
    localparam logic [11:0] IND_BASE1   = 12'hfd8;
    localparam logic [11:0] IND_BASE2   = 12'hfe0;
    localparam logic [11:0] IND_SPAN    = 12'h005;

    typedef enum logic [1:0] {ST_IDLE, ST_MOVE2, ST_CALL_NOP} exec_state_t;
endpackage

//--- mem_port_if.sv
// Data memory port between the executor and its data memory
`timescale 1ns/1ps
interface mem_port_if;
    logic        rd_en;
    logic [11:0] rd_addr;
    logic [7:0]  rd_data;
    logic        wr_en;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;
    modport core (output rd_en, rd_addr, wr_en, wr_addr, wr_data,
                  input rd_data);
    modport mem  (input rd_en, rd_addr, wr_en, wr_addr, wr_data,
                  output rd_data);
endinterface

//--- data_memory.sv
// Byte-wide data memory with registered read data
`timescale 1ns/1ps
module data_memory #(
    parameter int DEPTH = stack_exec_pkg::MEM_DEPTH
) (
    input  wire logic   clk_in,
    mem_port_if.mem     port
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rd_data_q;

    always_ff @(posedge clk_in) begin
        if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    // Read data holds until the next enabled read
    always_ff @(posedge clk_in) begin
        if (port.rd_en) begin
            rd_data_q <= mem_q[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_q;
endmodule

//--- extended_stack_instr_exec.sv
// Executor for computed call, indexed moves and literal push
// Contract
// RQ1 - A computed call pushes the following address, PC plus two, first.
// RQ2 - A computed call loads the working register into the PC low byte.
// RQ3 - A computed call copies the high and upper latches into PC bits.
// RQ4 - A computed call takes one word and two cycles, the second a no-op.
// RQ5 - A computed call saves and restores no working, status or bank reg.
// RQ6 - The absolute move source is the stack pointer plus a 7-bit offset.
// RQ7 - The absolute move destination is the 12-bit field of word two.
// RQ8 - Move addresses reach the whole 4096-byte data space.
// RQ9 - Programs never target the PC low byte or return stack top bytes.
// RQ10 - An indexed move whose source is an indirect register moves 00h.
// RQ11 - The indexed move uses stack pointer plus a per-word 7-bit offset.
// RQ12 - An indexed move to an indirect register writes nothing.
// RQ13 - A literal push writes its byte at the stack pointer in one cycle.
// RQ14 - After a literal push the stack pointer drops by one.
// RQ15 - No flags change; moves take two words, read first, write second.
`timescale 1ns/1ps
module extended_stack_instr_exec (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Instruction stream
    input  wire logic        instr_valid_in,
    input  wire logic [15:0] instr_word_in,
    // Core registers
    input  wire logic [7:0]  working_register_in,
    input  wire logic [7:0]  program_counter_high_latch_in,
    input  wire logic [4:0]  program_counter_upper_latch_in,
    // Stack pointer load
    input  wire logic        ssp_load_in,
    input  wire logic [11:0] ssp_value_in,
    // Memory preload
    input  wire logic        ext_wr_in,
    input  wire logic [11:0] ext_addr_in,
    input  wire logic [7:0]  ext_data_in,
    // Program flow
    output logic [20:0]      program_counter_out,
    output logic             return_push_out,
    output logic [20:0]      return_addr_out,
    output logic [11:0]      software_stack_pointer_out,
    // Executed data writes
    output logic             data_wr_out,
    output logic [11:0]      data_addr_out,
    output logic [7:0]       data_out
);
    mem_port_if port ();

    stack_exec_pkg::exec_state_t state_q;
    logic [20:0] pc_q;
    logic [11:0] ssp_q;
    logic        push_q;
    logic [20:0] push_addr_q;
    logic        obs_wr_q;
    logic [11:0] obs_addr_q;
    logic [7:0]  obs_data_q;
    logic        move_ss_q;
    logic        src_ind_q;

    function automatic logic [11:0] idx_addr(input logic [11:0] base,
                                             input logic [6:0]  off);
        idx_addr = base + {5'h00, off};
    endfunction

    function automatic logic is_indirect(input logic [11:0] a);
        logic [11:0] d0;
        logic [11:0] d1;
        logic [11:0] d2;
        d0 = a - stack_exec_pkg::IND_BASE0;
        d1 = a - stack_exec_pkg::IND_BASE1;
        d2 = a - stack_exec_pkg::IND_BASE2;
        is_indirect = (d0 < stack_exec_pkg::IND_SPAN)
                   || (d1 < stack_exec_pkg::IND_SPAN)
                   || (d2 < stack_exec_pkg::IND_SPAN);
    endfunction

    logic        idle_go;
    logic        is_call;
    logic        is_move;
    logic        is_push;
    logic        move2_go;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic        dst_blocked;
    logic        core_wr;
    logic [11:0] core_wr_addr;
    logic [7:0]  core_wr_data;

    always_comb begin
        idle_go  = instr_valid_in && (state_q == stack_exec_pkg::ST_IDLE);
        move2_go = instr_valid_in && (state_q == stack_exec_pkg::ST_MOVE2);
        is_call  = idle_go && (instr_word_in == stack_exec_pkg::OP_CALL);
        is_move  = idle_go
                && (instr_word_in[15:8] == stack_exec_pkg::OP_MOVE_HI);
        is_push  = idle_go
                && (instr_word_in[15:8] == stack_exec_pkg::OP_PUSH_HI);
        src_addr = idx_addr(ssp_q, instr_word_in[6:0]); // RQ6 RQ11
        // Second word of the indexed form carries its own offset
        dst_addr = move_ss_q ? idx_addr(ssp_q, instr_word_in[6:0]) // RQ11
                             : instr_word_in[11:0]; // RQ7 RQ8
        dst_blocked = move_ss_q && is_indirect(dst_addr); // RQ12
        core_wr      = 1'b0;
        core_wr_addr = ssp_q;
        core_wr_data = instr_word_in[7:0];
        if (is_push) begin
            core_wr = 1'b1; // RQ13
        end else if (move2_go) begin
            core_wr      = !dst_blocked; // RQ12 RQ15
            core_wr_addr = dst_addr;
            core_wr_data = src_ind_q ? stack_exec_pkg::NULL_DATA
                                     : port.rd_data; // RQ10
        end
    end

    // Core writes win; a preload in the same cycle is dropped
    always_comb begin
        port.rd_en   = is_move; // RQ15
        port.rd_addr = src_addr;
        port.wr_en   = core_wr || ext_wr_in;
        port.wr_addr = core_wr ? core_wr_addr : ext_addr_in;
        port.wr_data = core_wr ? core_wr_data : ext_data_in;
    end

    data_memory #(
        .DEPTH (stack_exec_pkg::MEM_DEPTH)
    ) i_data_memory (
        .clk_in (ref_clk_in),
        .port   (port.mem)
    );

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= stack_exec_pkg::ST_IDLE;
        end else begin
            case (state_q)
                stack_exec_pkg::ST_IDLE: begin
                    if (is_call) begin
                        state_q <= stack_exec_pkg::ST_CALL_NOP; // RQ4
                    end else if (is_move) begin
                        state_q <= stack_exec_pkg::ST_MOVE2; // RQ15
                    end
                end
                stack_exec_pkg::ST_MOVE2: begin
                    if (instr_valid_in) begin
                        state_q <= stack_exec_pkg::ST_IDLE;
                    end
                end
                stack_exec_pkg::ST_CALL_NOP: begin
                    state_q <= stack_exec_pkg::ST_IDLE; // RQ4
                end
                default: begin
                    state_q <= stack_exec_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Move context captured with the first word
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            move_ss_q <= 1'b0;
            src_ind_q <= 1'b0;
        end else if (is_move) begin
            move_ss_q <= instr_word_in[stack_exec_pkg::MOVE_SS_BIT];
            src_ind_q <= is_indirect(src_addr); // RQ10
        end
    end

    // Program counter; the flush cycle's stale word does not advance it
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pc_q <= stack_exec_pkg::RESET_PC;
        end else if (is_call) begin
            // Working register only read, never saved or restored
            pc_q <= {program_counter_upper_latch_in,
                     program_counter_high_latch_in, // RQ3
                     working_register_in}; // RQ2 RQ5
        end else if (instr_valid_in
                     && state_q != stack_exec_pkg::ST_CALL_NOP) begin
            pc_q <= pc_q + stack_exec_pkg::PC_STEP;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            push_q      <= 1'b0;
            push_addr_q <= stack_exec_pkg::RESET_PC;
        end else begin
            push_q <= is_call; // RQ1
            if (is_call) begin
                push_addr_q <= pc_q + stack_exec_pkg::PC_STEP; // RQ1
            end
        end
    end

    // External load has priority over the push decrement
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ssp_q <= stack_exec_pkg::RESET_SSP;
        end else if (ssp_load_in) begin
            ssp_q <= ssp_value_in;
        end else if (is_push) begin
            ssp_q <= ssp_q - stack_exec_pkg::SSP_STEP; // RQ14
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            obs_wr_q   <= 1'b0;
            obs_addr_q <= stack_exec_pkg::RESET_SSP;
            obs_data_q <= stack_exec_pkg::NULL_DATA;
        end else begin
            obs_wr_q <= core_wr;
            if (core_wr) begin
                obs_addr_q <= core_wr_addr;
                obs_data_q <= core_wr_data;
            end
        end
    end

    assign program_counter_out        = pc_q;
    assign return_push_out            = push_q;
    assign return_addr_out            = push_addr_q;
    assign software_stack_pointer_out = ssp_q;
    assign data_wr_out                = obs_wr_q;
    assign data_addr_out              = obs_addr_q;
    assign data_out                   = obs_data_q;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    call_push_a: assert property (is_call |=> // RQ1
        push_q && push_addr_q == $past(pc_q) + stack_exec_pkg::PC_STEP)
        else $error("call did not push return address");
    call_low_a: assert property (is_call |=> // RQ2
        pc_q[7:0] == $past(working_register_in))
        else $error("call low byte wrong");
    call_high_a: assert property (is_call |=> // RQ3
        pc_q[20:8] == {$past(program_counter_upper_latch_in),
                       $past(program_counter_high_latch_in)})
        else $error("call high bytes wrong");
    call_nop_a: assert property (is_call |=> // RQ4
        state_q == stack_exec_pkg::ST_CALL_NOP ##1
        ($stable(pc_q) && !obs_wr_q && state_q == stack_exec_pkg::ST_IDLE))
        else $error("call second cycle not a no-op");
    move_src_a: assert property (is_move |-> // RQ6
        port.rd_en && port.rd_addr == ssp_q + {5'h00, instr_word_in[6:0]})
        else $error("move source address wrong");
    abs_dest_a: assert property (move2_go && !move_ss_q |=> // RQ7
        obs_wr_q && obs_addr_q == $past(instr_word_in[11:0]))
        else $error("absolute move destination wrong");
    src_null_a: assert property (move2_go && src_ind_q && !dst_blocked
        |=> obs_wr_q && obs_data_q == stack_exec_pkg::NULL_DATA) // RQ10
        else $error("indirect source did not read zero");
    dest_nop_a: assert property (move2_go && move_ss_q // RQ12
        && is_indirect(dst_addr) |=> !obs_wr_q)
        else $error("indirect destination was written");
    push_write_a: assert property (is_push |=> obs_wr_q // RQ13
        && obs_addr_q == $past(ssp_q)
        && obs_data_q == $past(instr_word_in[7:0]))
        else $error("push write wrong");
    push_dec_a: assert property (is_push && !ssp_load_in |=> // RQ14
        ssp_q == $past(ssp_q) - stack_exec_pkg::SSP_STEP)
        else $error("push did not decrement pointer");
    move_two_a: assert property (is_move && !instr_word_in[7] ##1 // RQ15
        instr_valid_in |=> obs_wr_q)
        else $error("move did not write in second cycle");

    call_seen_c: cover property (is_call);
    abs_move_c: cover property (move2_go && !move_ss_q);
    idx_move_c: cover property (move2_go && move_ss_q);
    push_seen_c: cover property (is_push ##1 is_push);
endmodule

//--- tb_extended_stack_instr_exec.sv
// Self-checking bench for the extended stack instruction executor
`timescale 1ns/1ps
module tb_extended_stack_instr_exec;
    logic        ref_clk_in;
    logic        rst_in;
    logic        instr_valid_in;
    logic [15:0] instr_word_in;
    logic [7:0]  working_register_in;
    logic [7:0]  program_counter_high_latch_in;
    logic [4:0]  program_counter_upper_latch_in;
    logic        ssp_load_in;
    logic [11:0] ssp_value_in;
    logic        ext_wr_in;
    logic [11:0] ext_addr_in;
    logic [7:0]  ext_data_in;
    logic [20:0] program_counter_out;
    logic        return_push_out;
    logic [20:0] return_addr_out;
    logic [11:0] software_stack_pointer_out;
    logic        data_wr_out;
    logic [11:0] data_addr_out;
    logic [7:0]  data_out;
    int          err_count;
    int          checked;

    extended_stack_instr_exec i_extended_stack_instr_exec (
        .ref_clk_in                    (ref_clk_in),
        .rst_in                        (rst_in),
        .instr_valid_in                (instr_valid_in),
        .instr_word_in                 (instr_word_in),
        .working_register_in           (working_register_in),
        .program_counter_high_latch_in (program_counter_high_latch_in),
        .program_counter_upper_latch_in(program_counter_upper_latch_in),
        .ssp_load_in                   (ssp_load_in),
        .ssp_value_in                  (ssp_value_in),
        .ext_wr_in                     (ext_wr_in),
        .ext_addr_in                   (ext_addr_in),
        .ext_data_in                   (ext_data_in),
        .program_counter_out           (program_counter_out),
        .return_push_out               (return_push_out),
        .return_addr_out               (return_addr_out),
        .software_stack_pointer_out    (software_stack_pointer_out),
        .data_wr_out                   (data_wr_out),
        .data_addr_out                 (data_addr_out),
        .data_out                      (data_out)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input logic [20:0] seen, input logic [20:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Word stays valid; caller lowers it with idle
    task automatic issue(input logic [15:0] w);
        instr_valid_in = 1'b1;
        instr_word_in  = w;
        @(posedge ref_clk_in);
        #10;
    endtask

    task automatic idle();
        instr_valid_in = 1'b0;
        @(posedge ref_clk_in);
        #10;
    endtask

    task automatic preload(input logic [11:0] a, input logic [7:0] d);
        ext_wr_in   = 1'b1;
        ext_addr_in = a;
        ext_data_in = d;
        @(posedge ref_clk_in);
        #10;
        ext_wr_in = 1'b0;
    endtask

    task automatic load_ssp(input logic [11:0] v);
        ssp_load_in  = 1'b1;
        ssp_value_in = v;
        @(posedge ref_clk_in);
        #10;
        ssp_load_in = 1'b0;
    endtask

    // Checks the write pulse of a finished move or push
    task automatic expect_wr(input logic [11:0] a, input logic [7:0] d);
        check({20'h0, data_wr_out}, 21'h1, "write pulse");
        check({9'h0, data_addr_out}, {9'h0, a}, "write address");
        check({13'h0, data_out}, {13'h0, d}, "write data");
    endtask

    task automatic run_reset();
        check(program_counter_out, 21'h0, "pc after reset");
        check({9'h0, software_stack_pointer_out}, 21'h0, "ssp after reset");
        check({20'h0, data_wr_out}, 21'h0, "no write in reset");
    endtask

    task automatic run_call();
        working_register_in            = 8'h06;
        program_counter_high_latch_in  = 8'h10;
        program_counter_upper_latch_in = 5'h05;
        issue(16'h0000);
        issue(16'h0014);
        check({20'h0, return_push_out}, 21'h1, "return push");
        check(return_addr_out, 21'h000004, "return address");
        check({13'h0, program_counter_out[7:0]}, 21'h06, "pc low");
        check({8'h0, program_counter_out[20:8]}, 21'h0510, "pc hi");
        issue(16'hfa77);
        check({20'h0, data_wr_out}, 21'h0, "flushed word");
        check(program_counter_out, 21'h051006, "pc held in nop");
        check({20'h0, return_push_out}, 21'h0, "single push");
        idle();
    endtask

    task automatic run_push();
        load_ssp(12'h1ec);
        issue(16'hfa08);
        expect_wr(12'h1ec, 8'h08);
        check({9'h0, software_stack_pointer_out}, 21'h1eb, "ssp");
        issue(16'hfaff);
        expect_wr(12'h1eb, 8'hff);
        check({9'h0, software_stack_pointer_out}, 21'h1ea, "ssp");
        // Pushed byte read back through an absolute move
        issue(16'heb02);
        check({20'h0, data_wr_out}, 21'h0, "no write on word one");
        issue(16'hf300);
        expect_wr(12'h300, 8'h08);
        idle();
    endtask

    task automatic run_moves();
        preload(12'h085, 8'h33);
        preload(12'hfff, 8'h5a);
        load_ssp(12'h080);
        issue(16'heb05);
        issue(16'hf123);
        expect_wr(12'h123, 8'h33);
        issue(16'heb85);
        issue(16'hf006);
        expect_wr(12'h086, 8'h33);
        idle();
        load_ssp(12'hf80);
        issue(16'heb7f);
        issue(16'hffff);
        expect_wr(12'hfff, 8'h5a);
        issue(16'heb7f);
        issue(16'hf000);
        expect_wr(12'h000, 8'h5a);
        idle();
    endtask

    task automatic run_indirect();
        preload(12'hfd0, 8'h55);
        preload(12'hfe5, 8'h66);
        load_ssp(12'hfd0);
        issue(16'heb00);
        issue(16'hf200);
        expect_wr(12'h200, 8'h00);
        issue(16'heb80);
        issue(16'hf020);
        expect_wr(12'hff0, 8'h00);
        issue(16'heb95);
        issue(16'hf010);
        check({20'h0, data_wr_out}, 21'h0, "indirect dest");
        issue(16'heb95);
        issue(16'hf01c);
        expect_wr(12'hfec, 8'h66);
        idle();
    endtask

    initial begin
        err_count                      = 0;
        checked                        = 0;
        rst_in                         = 1'b1;
        instr_valid_in                 = 1'b0;
        instr_word_in                  = 16'h0000;
        working_register_in            = 8'h00;
        program_counter_high_latch_in  = 8'h00;
        program_counter_upper_latch_in = 5'h00;
        ssp_load_in                    = 1'b0;
        ssp_value_in                   = 12'h000;
        ext_wr_in                      = 1'b0;
        ext_addr_in                    = 12'h000;
        ext_data_in                    = 8'h00;
        repeat (5) @(posedge ref_clk_in);
        #10;
        rst_in = 1'b0;
        run_reset();
        run_call();
        run_push();
        run_moves();
        run_indirect();
        tally_and_finish();
    end
endmodule
